//--- output_force_disarm_override.sv
// Test-mode force and disarm override for relay outputs and measured channels
// Behaviour
// R1 - A command forces output contacts to a chosen position, permanent or timed.
// R2 - A timed force holds only while its timer runs, then releases.
// R3 - A permanent force holds continuously with no automatic release.
// R4 - Single or group force; group force beats single force in that group.
// R5 - A force is ignored for any contact that is disarmed.
// R6 - Force applies only when not disarmed and the direct command is given.
// R7 - Disarm mode blocks switching of whole groups of output contacts.
// R8 - Zone interlock output and supervision contact are never disarmed.
// R9 - Disarm is permanent or timed; timed disarm ends when its timer expires.
// R10 - Disarm needs unlatched, no hold timer, control active and direct command.
// R11 - Temperature readings may be forced, permanent or timed, then restored.
// R12 - View shows live values, freezes while forcing, then live again.
// R13 - Analog outputs may be forced, permanent or timed, then revert.
// R14 - Analog inputs may be forced, permanent or timed, then revert.
// R15 - Each timeout is its own down-counter loaded at activation, releasing at zero.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module output_force_disarm_override
   import ovr_pkg::*;
#(
   parameter int N_OUT = NUM_OUT,
   parameter int N_GRP = NUM_GRP,
   parameter int N_CH = NUM_CH
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [N_OUT-1:0] out_normal,
   input wire logic [N_OUT-1:0] out_latched,
   input wire logic [N_OUT-1:0] out_hold_running,
   output logic [N_OUT-1:0] out_contact,
   input wire logic [CH_W-1:0] temp_live [N_CH],
   input wire logic [CH_W-1:0] aout_live [N_CH],
   input wire logic [CH_W-1:0] ain_live [N_CH],
   output logic [CH_W-1:0] temp_value [N_CH],
   output logic [CH_W-1:0] aout_value [N_CH],
   output logic [CH_W-1:0] ain_value [N_CH]
);
   localparam int GS = N_OUT / N_GRP;
   localparam int NK = 3;

   // Status packs contacts and groups into bytes, so larger setups are refused
   generate
      if (N_OUT > 8 || N_GRP < 1 || N_GRP > 8 || N_OUT % N_GRP != 0
         || N_CH < 1 || N_CH > 8) begin : g_bad_cfg
         $error("Unsupported output, group or channel count");
      end
   endgenerate

   // Group of a contact, used by force and disarm paths
   function automatic int grp_of(input int i);
      return i / GS;
   endfunction

   // Disarm eligibility excludes zone interlock and supervision contacts
   function automatic logic may_disarm(input int i);
      return (i != int'(ZONE_OUT_IDX)) && (i != int'(SUPV_OUT_IDX));
   endfunction

   // Only kind and index values inside range name a real channel
   function automatic logic ch_ok(input logic [2:0] kind, input logic [2:0] idx);
      return int'(kind) < NK && int'(idx) < N_CH;
   endfunction

   // Flat slot of a channel; an unchecked index would alias into the next kind
   function automatic int ch_slot(input logic [2:0] kind, input logic [2:0] idx);
      return int'(kind) * N_CH + int'(idx);
   endfunction

   logic [31:0] fsel_r, fsel_nxt, fpos_r, fpos_nxt, fctl_r, fctl_nxt;
   logic [31:0] ftmo_r, ftmo_nxt, dctl_r, dctl_nxt, dtmo_r, dtmo_nxt;
   logic [31:0] cctl_r, cctl_nxt, ctmo_r, ctmo_nxt;
   logic [CH_W-1:0] cval_r [NK*N_CH];
   logic [CH_W-1:0] cval_nxt [NK*N_CH];
   logic [CH_W-1:0] view_r [NK*N_CH];
   logic [CH_W-1:0] view_nxt [NK*N_CH];
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   logic wr_en, rd_en;
   logic f_start, f_stop, d_start, d_stop;
   logic [N_OUT-1:0] f_single_start, f_single_stop, f_single_act;
   logic [N_GRP-1:0] f_grp_start, f_grp_stop, f_grp_act;
   logic [N_GRP-1:0] d_grp_start, d_grp_stop, d_grp_act;
   logic [NK*N_CH-1:0] c_start, c_stop, c_act;
   logic [N_OUT-1:0] disarmed_r, disarmed_nxt, cont_r, cont_nxt;
   logic [N_OUT-1:0] fpos_out;
   logic [CH_W-1:0] live [NK*N_CH];
   logic [CH_W-1:0] cout_r [NK*N_CH];
   logic [CH_W-1:0] cout_nxt [NK*N_CH];
   logic [2:0] c_kind;
   logic [2:0] c_idx;
   logic [2:0] w_kind, w_idx;

   // Live values of all channels laid out kind by kind
   generate
      for (genvar c = 0; c < N_CH; c++) begin : g_live
         assign live[int'(CK_TEMP)*N_CH+c] = temp_live[c];
         assign live[int'(CK_AOUT)*N_CH+c] = aout_live[c];
         assign live[int'(CK_AIN)*N_CH+c] = ain_live[c];
         assign temp_value[c] = cout_r[int'(CK_TEMP)*N_CH+c];
         assign aout_value[c] = cout_r[int'(CK_AOUT)*N_CH+c];
         assign ain_value[c] = cout_r[int'(CK_AIN)*N_CH+c];
      end
   endgenerate

   // Slave answers in the access cycle; write takes effect at that edge
   assign wr_en = psel && penable && pwrite && pready_r;
   assign rd_en = psel && !penable && !pwrite;
   assign fpos_out = fpos_r[N_OUT-1:0];
   assign c_kind = cctl_r[CC_SEL_LSB+4 +: 3];
   assign c_idx = cctl_r[CC_SEL_LSB +: 3];
   assign w_kind = pwdata[CC_SEL_LSB+4 +: 3];
   assign w_idx = pwdata[CC_SEL_LSB +: 3];

   // Command strobes derived from control register writes
   always_comb begin
      f_start = wr_en && paddr == OFS_FORCE_CTL && pwdata[FC_CMD_BIT];
      f_stop = wr_en && paddr == OFS_FORCE_CTL && !pwdata[FC_CMD_BIT];
      d_start = wr_en && paddr == OFS_DISARM_CTL && pwdata[DC_CMD_BIT] && pwdata[DC_CTRL_BIT];
      d_stop = wr_en && paddr == OFS_DISARM_CTL && !(pwdata[DC_CMD_BIT] && pwdata[DC_CTRL_BIT]);
      for (int g = 0; g < N_GRP; g++) begin
         f_grp_start[g] = f_start && pwdata[FC_GROUP_BIT] && pwdata[FC_GSEL_LSB +: 4] == 4'(g);
         f_grp_stop[g] = f_stop && pwdata[FC_GROUP_BIT] && pwdata[FC_GSEL_LSB +: 4] == 4'(g);
         d_grp_start[g] = d_start && pwdata[DC_GSEL_LSB +: 4] == 4'(g); // R10
         d_grp_stop[g] = d_stop && pwdata[DC_GSEL_LSB +: 4] == 4'(g);
      end
      for (int i = 0; i < N_OUT; i++) begin
         f_single_start[i] = f_start && !pwdata[FC_GROUP_BIT] && fsel_r[i];
         f_single_stop[i] = f_stop && !pwdata[FC_GROUP_BIT] && fsel_r[i];
      end
      for (int k = 0; k < NK*N_CH; k++) begin
         c_start[k] = wr_en && paddr == OFS_CH_CTL && pwdata[CC_CMD_BIT]
            && ch_ok(w_kind, w_idx) && ch_slot(w_kind, w_idx) == k;
         c_stop[k] = wr_en && paddr == OFS_CH_CTL && !pwdata[CC_CMD_BIT]
            && ch_ok(w_kind, w_idx) && ch_slot(w_kind, w_idx) == k;
      end
   end

   // One independent timeout counter per override
   generate
      for (genvar i = 0; i < N_OUT; i++) begin : g_fs
         ovr_timer #(.W(TMR_W)) u_t (.clk(clk), .srst(srst), .start(f_single_start[i]),
            .stop(f_single_stop[i]), .timed(pwdata[FC_TIMED_BIT]), .load(ftmo_r),
            .active(f_single_act[i])); // R1 R15
      end
      for (genvar g = 0; g < N_GRP; g++) begin : g_grp
         ovr_timer #(.W(TMR_W)) u_f (.clk(clk), .srst(srst), .start(f_grp_start[g]),
            .stop(f_grp_stop[g]), .timed(pwdata[FC_TIMED_BIT]), .load(ftmo_r),
            .active(f_grp_act[g])); // R4 R15
         ovr_timer #(.W(TMR_W)) u_d (.clk(clk), .srst(srst), .start(d_grp_start[g]),
            .stop(d_grp_stop[g]), .timed(pwdata[DC_TIMED_BIT]), .load(dtmo_r),
            .active(d_grp_act[g])); // R9 R15
      end
      for (genvar k = 0; k < NK*N_CH; k++) begin : g_ch
         ovr_timer #(.W(TMR_W)) u_c (.clk(clk), .srst(srst), .start(c_start[k]),
            .stop(c_stop[k]), .timed(pwdata[CC_TIMED_BIT]), .load(ctmo_r),
            .active(c_act[k])); // R11 R13 R14 R15
      end
   endgenerate

   // Contact path: disarm entry is gated, once disarmed the contact is frozen
   always_comb begin
      for (int i = 0; i < N_OUT; i++) begin
         disarmed_nxt[i] = 1'b0;
         if (d_grp_act[grp_of(i)] && may_disarm(i)) begin // R7 R8
            // Entry needs no latch and no hold; once entered it stays for the timer
            disarmed_nxt[i] = disarmed_r[i] || (!out_latched[i] && !out_hold_running[i]); // R10
         end
         if (disarmed_r[i]) begin
            cont_nxt[i] = cont_r[i]; // R7 R5
         end else if (f_grp_act[grp_of(i)]) begin
            cont_nxt[i] = fpos_out[i]; // R4 R6
         end else if (f_single_act[i]) begin
            cont_nxt[i] = fpos_out[i]; // R1 R6
         end else begin
            cont_nxt[i] = out_normal[i]; // R2
         end
      end
   end

   // Contact state registers
   always_ff @(posedge clk) begin
      if (srst) begin
         disarmed_r <= '0;
         cont_r <= '0;
      end else begin
         disarmed_r <= disarmed_nxt;
         cont_r <= cont_nxt;
      end
   end

   // Channel path: forced value while active, view frozen while forcing
   always_comb begin
      for (int k = 0; k < NK*N_CH; k++) begin
         cout_nxt[k] = c_act[k] ? cval_r[k] : live[k]; // R11 R13 R14
         view_nxt[k] = c_act[k] ? view_r[k] : live[k]; // R12
      end
   end

   // Channel state registers
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int k = 0; k < NK*N_CH; k++) begin
            view_r[k] <= '0;
            cout_r[k] <= '0;
         end
      end else begin
         view_r <= view_nxt;
         cout_r <= cout_nxt;
      end
   end

   // Register writes and read mux
   always_comb begin
      fsel_nxt = fsel_r;
      fpos_nxt = fpos_r;
      fctl_nxt = fctl_r;
      ftmo_nxt = ftmo_r;
      dctl_nxt = dctl_r;
      dtmo_nxt = dtmo_r;
      cctl_nxt = cctl_r;
      ctmo_nxt = ctmo_r;
      cval_nxt = cval_r;
      prdata_nxt = prdata_r;
      pready_nxt = psel && !penable;
      pslverr_nxt = 1'b0;
      if (wr_en) begin
         unique case (paddr)
            OFS_FORCE_SEL: fsel_nxt = pwdata;
            OFS_FORCE_POS: fpos_nxt = pwdata;
            OFS_FORCE_CTL: fctl_nxt = pwdata;
            OFS_FORCE_TMO: ftmo_nxt = pwdata;
            OFS_DISARM_CTL: dctl_nxt = pwdata;
            OFS_DISARM_TMO: dtmo_nxt = pwdata;
            OFS_CH_CTL: cctl_nxt = pwdata;
            OFS_CH_TMO: ctmo_nxt = pwdata;
            OFS_CH_VAL: begin
               if (ch_ok(c_kind, c_idx)) begin
                  cval_nxt[ch_slot(c_kind, c_idx)] = pwdata[CH_W-1:0];
               end
            end
            default: ;
         endcase
      end
      if (psel && !penable) begin
         pslverr_nxt = 1'b0;
         unique case (paddr)
            OFS_FORCE_SEL: prdata_nxt = fsel_r;
            OFS_FORCE_POS: prdata_nxt = fpos_r;
            OFS_FORCE_CTL: prdata_nxt = fctl_r;
            OFS_FORCE_TMO: prdata_nxt = ftmo_r;
            OFS_DISARM_CTL: prdata_nxt = dctl_r;
            OFS_DISARM_TMO: prdata_nxt = dtmo_r;
            OFS_OUT_STAT: prdata_nxt = {8'h00, 8'(f_grp_act), 8'(disarmed_r), 8'(cont_r)};
            OFS_CH_CTL: prdata_nxt = {8'(c_act), 8'h00, cctl_r[15:0]};
            OFS_CH_TMO: prdata_nxt = ctmo_r;
            OFS_CH_VAL: prdata_nxt = ch_ok(c_kind, c_idx) ?
               32'(cval_r[ch_slot(c_kind, c_idx)]) : 32'h0000_0000;
            OFS_CH_VIEW: prdata_nxt = ch_ok(c_kind, c_idx) ?
               32'(view_r[ch_slot(c_kind, c_idx)]) : 32'h0000_0000; // R12
            default: begin
               prdata_nxt = 32'h0000_0000;
               pslverr_nxt = 1'b1;
            end
         endcase
         if (!rd_en && pwrite) begin
            prdata_nxt = 32'h0000_0000;
         end
      end
   end

   // Register file and bus answer registers
   always_ff @(posedge clk) begin
      if (srst) begin
         fsel_r <= REG_RST;
         fpos_r <= REG_RST;
         fctl_r <= REG_RST;
         ftmo_r <= REG_RST;
         dctl_r <= REG_RST;
         dtmo_r <= REG_RST;
         cctl_r <= REG_RST;
         ctmo_r <= REG_RST;
         prdata_r <= REG_RST;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         for (int k = 0; k < NK*N_CH; k++) begin
            cval_r[k] <= '0;
         end
      end else begin
         fsel_r <= fsel_nxt;
         fpos_r <= fpos_nxt;
         fctl_r <= fctl_nxt;
         ftmo_r <= ftmo_nxt;
         dctl_r <= dctl_nxt;
         dtmo_r <= dtmo_nxt;
         cctl_r <= cctl_nxt;
         ctmo_r <= ctmo_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         cval_r <= cval_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign out_contact = cont_r;
endmodule

//--- ovr_pkg.sv
// Package with register map, field layout and constants for the override block
package ovr_pkg;
   localparam int NUM_OUT = 8;
   localparam int NUM_GRP = 2;
   localparam int OUT_PER_GRP = 4;
   localparam int NUM_CH = 4;
   localparam int CH_W = 16;
   localparam int TMR_W = 32;
   localparam logic [7:0] ZONE_OUT_IDX = 8'h06;
   localparam logic [7:0] SUPV_OUT_IDX = 8'h07;
   // Register byte offsets
   localparam logic [11:0] OFS_FORCE_SEL = 12'h000;
   localparam logic [11:0] OFS_FORCE_POS = 12'h004;
   localparam logic [11:0] OFS_FORCE_CTL = 12'h008;
   localparam logic [11:0] OFS_FORCE_TMO = 12'h00C;
   localparam logic [11:0] OFS_DISARM_CTL = 12'h010;
   localparam logic [11:0] OFS_DISARM_TMO = 12'h014;
   localparam logic [11:0] OFS_OUT_STAT = 12'h018;
   localparam logic [11:0] OFS_CH_CTL = 12'h01C;
   localparam logic [11:0] OFS_CH_TMO = 12'h020;
   localparam logic [11:0] OFS_CH_VAL = 12'h040;
   localparam logic [11:0] OFS_CH_VIEW = 12'h080;
   // Control field positions
   localparam int FC_CMD_BIT = 0;
   localparam int FC_TIMED_BIT = 1;
   localparam int FC_GROUP_BIT = 2;
   localparam int FC_GSEL_LSB = 4;
   localparam int DC_CTRL_BIT = 0;
   localparam int DC_CMD_BIT = 1;
   localparam int DC_TIMED_BIT = 2;
   localparam int DC_GSEL_LSB = 4;
   localparam int CC_CMD_BIT = 0;
   localparam int CC_TIMED_BIT = 1;
   localparam int CC_SEL_LSB = 4;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   localparam logic [TMR_W-1:0] TMR_ZERO = '0;
   typedef enum logic [1:0] {CK_TEMP, CK_AOUT, CK_AIN} ch_kind_t;
endpackage

//--- ovr_timer.sv
// Down-counter that holds an override active permanently or until timeout
`timescale 1ns/100ps
module ovr_timer
   import ovr_pkg::*;
#(
   parameter int W = TMR_W
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic start,
   input wire logic stop,
   input wire logic timed,
   input wire logic [W-1:0] load,
   output logic active
);
   logic act_r, act_nxt, perm_r, perm_nxt;
   logic [W-1:0] cnt_r, cnt_nxt;

   // Start wins over stop so a fresh command is never lost
   always_comb begin
      act_nxt = act_r;
      perm_nxt = perm_r;
      cnt_nxt = cnt_r;
      if (start) begin
         act_nxt = 1'b1; // R15
         perm_nxt = !timed; // R3
         cnt_nxt = load; // R15
      end else if (stop) begin
         act_nxt = 1'b0;
      end else if (act_r && !perm_r) begin
         if (cnt_r <= W'(1)) begin
            act_nxt = 1'b0; // R2
            cnt_nxt = '0;
         end else begin
            cnt_nxt = cnt_r - W'(1); // R15
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         act_r <= 1'b0;
         perm_r <= 1'b0;
         cnt_r <= '0;
      end else begin
         act_r <= act_nxt;
         perm_r <= perm_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign active = act_r;
endmodule

//--- ovr_props.sv
// Port checker for the override block: APB answers and contact status
`timescale 1ns/100ps
module ovr_props
   import ovr_pkg::*;
#(
   parameter int N_OUT = NUM_OUT
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [N_OUT-1:0] out_contact
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic hit;
   // Offsets the block decodes; anything else must answer with an error
   assign hit = paddr inside {OFS_FORCE_SEL, OFS_FORCE_POS, OFS_FORCE_CTL, OFS_FORCE_TMO,
      OFS_DISARM_CTL, OFS_DISARM_TMO, OFS_OUT_STAT, OFS_CH_CTL, OFS_CH_TMO, OFS_CH_VAL,
      OFS_CH_VIEW};
   sequence s_setup; psel && !penable; endsequence
   sequence s_done; psel && penable && pready; endsequence
   sequence s_read; pready && !pwrite; endsequence
   property p_answer; s_setup |=> s_done; endproperty
   property p_only; pready |-> psel && penable; endproperty
   property p_once; s_done |=> !pready; endproperty
   property p_errack; pslverr |-> pready; endproperty
   property p_miss; s_read ##0 !hit |-> pslverr && prdata == 32'h0; endproperty
   property p_ok; s_done ##0 hit |-> !pslverr; endproperty
   // Status can never report the interlock or supervision contact as disarmed
   property p_keep; s_read ##0 paddr == OFS_OUT_STAT
      |-> !prdata[8 + ZONE_OUT_IDX] && !prdata[8 + SUPV_OUT_IDX]; endproperty
   property p_rst; $fell(srst) |-> out_contact == '0 && !pready; endproperty
   a_answer: assert property (p_answer) else $error("No answer after setup");
   a_only: assert property (p_only) else $error("Ready outside access");
   a_once: assert property (p_once) else $error("Ready longer than one cycle");
   a_errack: assert property (p_errack) else $error("Error without ready");
   a_miss: assert property (p_miss) else $error("Unmapped read not refused");
   a_ok: assert property (p_ok) else $error("Mapped access refused");
   a_keep: assert property (p_keep) else $error("Protected contact disarmed");
   a_rst: assert property (p_rst) else $error("Outputs not cleared by reset");
endmodule
bind output_force_disarm_override ovr_props #(.N_OUT(N_OUT)) props (.clk, .srst, .psel,
   .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .out_contact);

//--- ovr_model.sv
// Far side model: protection logic commands and live channel measurements
`timescale 1ns/100ps
module ovr_model
   import ovr_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [NUM_OUT-1:0] normal_cmd,
   input wire logic [NUM_OUT-1:0] latch_cmd,
   input wire logic [NUM_OUT-1:0] hold_cmd,
   input wire logic [CH_W-1:0] live_base,
   output logic [NUM_OUT-1:0] out_normal,
   output logic [NUM_OUT-1:0] out_latched,
   output logic [NUM_OUT-1:0] out_hold_running,
   output logic [CH_W-1:0] temp_live [NUM_CH],
   output logic [CH_W-1:0] aout_live [NUM_CH],
   output logic [CH_W-1:0] ain_live [NUM_CH]
);
   // Registered like real protection logic, so changes land one edge late
   always_ff @(posedge clk) begin
      out_normal <= srst ? '0 : normal_cmd;
      out_latched <= srst ? '0 : latch_cmd;
      out_hold_running <= srst ? '0 : hold_cmd;
      for (int i = 0; i < NUM_CH; i++) begin
         temp_live[i] <= live_base + 16'(i);
         aout_live[i] <= live_base + 16'(256 + i);
         ain_live[i] <= live_base + 16'(512 + i);
      end
   end
endmodule

//--- test_output_force_disarm_override.sv
// Self-checking bench for the output force and disarm override block
`timescale 1ns/100ps
module test_output_force_disarm_override;
   import ovr_pkg::*;
   logic clk = 0;
   logic srst = 1;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr, probe = 0;
   logic [1:0] pk = '0, pi = '0;
   logic [7:0] normal_cmd = '0, latch_cmd = '0, hold_cmd = '0;
   logic [15:0] live_base = 16'h0200;
   logic [7:0] out_normal, out_latched, out_hold_running, out_contact;
   logic [15:0] temp_live [4], aout_live [4], ain_live [4];
   logic [15:0] temp_value [4], aout_value [4], ain_value [4];
   logic [32:0] exp_q [$];
   logic [32:0] got;
   logic [31:0] rnd = 32'h02EBE005;
   int err_count = 0;
   int samples_checked = 0;
   always #25 clk = ~clk;
   output_force_disarm_override dut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .out_normal, .out_latched, .out_hold_running, .out_contact,
      .temp_live, .aout_live, .ain_live, .temp_value, .aout_value, .ain_value);
   ovr_model model (.clk, .srst, .normal_cmd, .latch_cmd, .hold_cmd, .live_base, .out_normal,
      .out_latched, .out_hold_running, .temp_live, .aout_live, .ain_live);
   task automatic end_sim();
      $display("Checked %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic cmp(input logic [32:0] seen, input logic [32:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // Read answers carry the error flag on top; probes pick all eight contacts or one channel
   assign got = !probe ? {pslverr, prdata} : pk == 2'h0 ? {25'h0, out_contact}
      : {17'h0, pk == 2'h1 ? temp_value[pi] : pk == 2'h2 ? aout_value[pi] : ain_value[pi]};
   always @(posedge clk) begin
      if (probe || (pready === 1'b1 && !pwrite)) begin
         cmp(got, exp_q.pop_front());
      end
   end
   // One APB transfer; a missing ready ends the run rather than hanging
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_count++;
         end_sim();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic chk(input logic [1:0] k, input logic [1:0] i, input logic [32:0] e);
      @(posedge clk);
      probe <= 1'b1;
      pk <= k;
      pi <= i;
      exp_q.push_back(e);
      @(posedge clk);
      probe <= 1'b0;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   function automatic logic [32:0] lv(input int k, input int i, input logic [15:0] b);
      return {17'h0, b + 16'(k * 256 + i)};
   endfunction
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   initial begin
      int k;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      rd(OFS_OUT_STAT, 33'h0);
      // Random traffic passes straight through while nothing is overridden
      for (int j = 0; j < 6; j++) begin
         rnd = xs(rnd);
         normal_cmd <= rnd[7:0];
         live_base <= rnd[31:16];
         cyc(4);
         k = rnd[9:8] % 3;
         chk(0, 0, {25'h0, rnd[7:0]});
         chk(2'(k + 1), rnd[11:10], lv(k, rnd[11:10], rnd[31:16]));
      end
      normal_cmd <= 8'h00;
      live_base <= 16'h0200;
      wr(OFS_FORCE_SEL, 32'h3);
      rd(OFS_FORCE_SEL, 33'h3);
      wr(OFS_FORCE_POS, 32'h1);
      chk(0, 0, 33'h0);
      wr(OFS_FORCE_CTL, 32'h1);
      cyc(40);
      chk(0, 0, 33'h1);
      wr(OFS_FORCE_CTL, 32'h0);
      cyc(4);
      chk(0, 0, 33'h0);
      wr(OFS_FORCE_TMO, 32'hA);
      wr(OFS_FORCE_CTL, 32'h3);
      cyc(1);
      chk(0, 0, 33'h1);
      // A load of ten keeps the force through the tenth edge after the write
      cyc(6);
      chk(0, 0, 33'h1);
      chk(0, 0, 33'h0);
      wr(OFS_FORCE_POS, 32'hF0);
      wr(OFS_FORCE_CTL, 32'h15);
      cyc(4);
      rd(OFS_OUT_STAT, 33'h0002_00F0);
      wr(OFS_FORCE_CTL, 32'h14);
      // Latched contact 0 and held contact 1 must escape the disarm
      normal_cmd <= 8'hFF;
      latch_cmd <= 8'h01;
      hold_cmd <= 8'h02;
      wr(OFS_DISARM_CTL, 32'h03);
      wr(OFS_DISARM_CTL, 32'h13);
      cyc(2);
      normal_cmd <= 8'h00;
      cyc(4);
      chk(0, 0, 33'h3C);
      rd(OFS_OUT_STAT, 33'h0000_3C3C);
      normal_cmd <= 8'hFF;
      wr(OFS_FORCE_POS, 32'h0);
      wr(OFS_FORCE_CTL, 32'h15);
      cyc(4);
      chk(0, 0, 33'h3F);
      wr(OFS_FORCE_CTL, 32'h14);
      wr(OFS_DISARM_CTL, 32'h00);
      wr(OFS_DISARM_CTL, 32'h10);
      latch_cmd <= 8'h00;
      hold_cmd <= 8'h00;
      cyc(4);
      chk(0, 0, 33'hFF);
      wr(OFS_DISARM_TMO, 32'h10);
      wr(OFS_DISARM_CTL, 32'h17);
      cyc(1);
      normal_cmd <= 8'h00;
      cyc(3);
      chk(0, 0, 33'h30);
      cyc(10);
      chk(0, 0, 33'h30);
      chk(0, 0, 33'h0);
      // Command without control, then control without command: no disarm
      wr(OFS_DISARM_CTL, 32'h12);
      normal_cmd <= 8'h30;
      cyc(4);
      chk(0, 0, 33'h30);
      wr(OFS_DISARM_CTL, 32'h11);
      normal_cmd <= 8'h00;
      cyc(4);
      chk(0, 0, 33'h0);
      // Each channel kind: forced value out, view frozen, then live again
      for (k = 0; k < 3; k++) begin
         live_base <= 16'h0200;
         wr(OFS_CH_CTL, 32'(k * 256 + (k + 1) * 16));
         wr(OFS_CH_VAL, 32'(16'hA000 + k));
         wr(OFS_CH_CTL, 32'(k * 256 + (k + 1) * 16 + 1));
         live_base <= 16'h0300;
         cyc(4);
         chk(2'(k + 1), 2'(k + 1), 33'(16'hA000 + k));
         rd(OFS_CH_VIEW, lv(k, k + 1, 16'h0200));
         wr(OFS_CH_CTL, 32'(k * 256 + (k + 1) * 16));
         cyc(4);
         chk(2'(k + 1), 2'(k + 1), lv(k, k + 1, 16'h0300));
         rd(OFS_CH_VIEW, lv(k, k + 1, 16'h0300));
      end
      wr(OFS_CH_TMO, 32'hA);
      wr(OFS_CH_VAL, 32'h5555);
      wr(OFS_CH_CTL, 32'h233);
      cyc(1);
      chk(2'h3, 2'h3, 33'h5555);
      cyc(6);
      chk(2'h3, 2'h3, 33'h5555);
      chk(2'h3, 2'h3, lv(2, 3, 16'h0300));
      wr(12'h100, 32'hFFFF);
      rd(12'h100, 33'h1_0000_0000);
      end_sim();
   end
endmodule
